// file: rtl/icbq_pkg.sv
// Register map, field positions and reset values of the capture block
package icbq_pkg;
    // Word indices; byte address is four times the index
    localparam logic [9:0] TIMER_IDX = 10'h084;
    localparam logic [9:0] EDGE_IDX  = 10'h08a;
    localparam logic [9:0] MASK_IDX  = 10'h08c;
    localparam logic [9:0] FLAG_IDX  = 10'h08e;
    localparam logic [9:0] CAP_IDX   = 10'h090;
    localparam logic [9:0] MCTL_IDX  = 10'h0a6;
    localparam logic [9:0] SCTL_IDX  = 10'h0ab;
    localparam logic [9:0] TEST_IDX  = 10'h0ad;
    localparam logic [9:0] MCNT_IDX  = 10'h0b6;
    localparam logic [9:0] HOLD_IDX  = 10'h0b8;
    localparam logic [9:0] PACC_IDX  = 10'h0c0;
    localparam logic [9:0] PHLD_IDX  = 10'h0c8;
    // capture_system_control_reg fields
    localparam int NO_OVERWRITE_BIT  = 0;
    localparam int LATCH_QUEUE_SELECT_BIT  = 1;
    localparam int HOLDING_BUFFER_ENABLE_BIT = 2;
    localparam int SAT_BIT   = 3;
    localparam int FLAG_TIMING_SELECT_BIT = 4;
    // modulus_control_reg fields
    localparam int MCEN_BIT  = 2;
    localparam int FORCE_BIT = 4;
    // Reset values and accumulator top count
    localparam logic [7:0]  CTRL_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [7:0]  PACC_MAX = 8'hff;
endpackage : icbq_pkg

// file: rtl/icbq_capture.sv
// Input capture front end with queue and latch holding registers
`timescale 1ns/1ps
module icbq_capture
    import icbq_pkg::*;
#(
    parameter int NCH = 4
) (
    // Clock and reset
    input  wire logic           CLK,
    input  wire logic           SYS_RST,
    // APB slave
    input  wire logic           PSEL,
    input  wire logic           PENABLE,
    input  wire logic           PWRITE,
    input  wire logic [11:0]    PADDR,
    input  wire logic [31:0]    PWDATA,
    output logic                PREADY,
    output logic                PSLVERR,
    output logic [31:0]         PRDATA,
    // Capture pins and mode
    input  wire logic [NCH-1:0] CAPTURE_PIN,
    input  wire logic           SPECIAL_MODE,
    // Interrupt
    output logic                IRQ
);
    typedef struct packed {
        logic [15:0]          timer;
        logic [NCH-1:0]       pin_prev;
        logic [15:0]          edge_sel;
        logic [7:0]           mask;
        logic [7:0]           flags;
        logic [7:0]           sysctl;
        logic [7:0]           modctl;
        logic [7:0]           test;
        logic [15:0]          mod_cnt;
        logic [15:0]          mod_load;
        logic [NCH-1:0][15:0] cap;
        logic [NCH-1:0][15:0] hold;
        logic [NCH-1:0][7:0]  pacc;
        logic [NCH-1:0][7:0]  pacc_hold;
        // Full marks track unread capture and holding words for the queue
        logic [NCH-1:0]       cap_full;
        logic [NCH-1:0]       hold_full;
        logic [31:0]          rdata;
    } icbq_state_t;

    icbq_state_t s_r;
    icbq_state_t s_nxt;

    logic [9:0]     idx;
    logic           wr_acc;
    logic           rd_acc;
    logic           holding_buffer_enable;
    logic           queue;
    logic           latch_ev;
    logic           mod_hit;
    logic [NCH-1:0] cap_ev;
    logic [NCH-1:0] hold_ld;

    // Channel register window test, used only by the error decode
    function automatic logic in_win(input logic [9:0] a,
                                    input logic [9:0] base);
        in_win = (a >= base) && (a < base + 10'(NCH));
    endfunction : in_win

    function automatic logic mapped(input logic [9:0] a);
        mapped = a == TIMER_IDX || a == EDGE_IDX || a == MASK_IDX ||
                 a == FLAG_IDX || a == MCTL_IDX || a == SCTL_IDX ||
                 a == TEST_IDX || a == MCNT_IDX || in_win(a, CAP_IDX) ||
                 in_win(a, HOLD_IDX) || in_win(a, PACC_IDX) ||
                 in_win(a, PHLD_IDX);
    endfunction : mapped

    assign idx     = PADDR[11:2];
    assign wr_acc  = PSEL && PENABLE && PWRITE;
    assign rd_acc  = PSEL && PENABLE && !PWRITE;
    // Zero-wait slave: every access completes in its first access cycle
    assign PREADY  = 1'b1;
    // Unmapped words answer with an error and ignore writes
    assign PSLVERR = PSEL && PENABLE && !mapped(idx);
    assign PRDATA  = s_r.rdata;
    assign IRQ     = |(s_r.flags & s_r.mask);

    always_comb begin
        s_nxt    = s_r;
        cap_ev   = '0;
        hold_ld  = '0;
        mod_hit  = 1'b0;
        holding_buffer_enable    = s_r.sysctl[HOLDING_BUFFER_ENABLE_BIT];
        queue    = holding_buffer_enable && !s_r.sysctl[LATCH_QUEUE_SELECT_BIT];
        s_nxt.timer    = s_r.timer + 16'h0001;
        // Pins are taken as synchronous, so one register of history suffices
        s_nxt.pin_prev = CAPTURE_PIN;

        // Modulus down-counter reloads so latching repeats periodically
        // A zero count parks the counter until the next count write
        if (s_r.modctl[MCEN_BIT] && s_r.mod_cnt != WORD_RST) begin
            s_nxt.mod_cnt = s_r.mod_cnt - 16'h0001;
            if (s_r.mod_cnt == 16'h0001) begin
                mod_hit       = 1'b1;
                s_nxt.mod_cnt = s_r.mod_load;
            end
        end
        // A zero write latches at once, counter enabled or not
        latch_ev = holding_buffer_enable && s_r.sysctl[LATCH_QUEUE_SELECT_BIT] && (mod_hit ||
                   (wr_acc && idx == MCNT_IDX &&
                    PWDATA[15:0] == WORD_RST) ||
                   (wr_acc && idx == MCTL_IDX &&
                    PWDATA[FORCE_BIT]));

        // Reads mark registers empty before new captures, so a set wins
        for (int c = 0; c < NCH; c++) begin
            if (rd_acc && idx == CAP_IDX + 10'(c)) begin
                s_nxt.cap_full[c] = 1'b0;
            end
            if (rd_acc && idx == HOLD_IDX + 10'(c)) begin
                s_nxt.hold_full[c] = 1'b0;
            end
        end

        // Register writes; flags are write-one-to-clear
        if (wr_acc) begin
            if (idx == EDGE_IDX) begin
                s_nxt.edge_sel = PWDATA[15:0];
            end else if (idx == MASK_IDX) begin
                s_nxt.mask = PWDATA[7:0];
            end else if (idx == FLAG_IDX) begin
                // Captures below run later, so a same-cycle set wins
                s_nxt.flags = s_r.flags & ~PWDATA[7:0];
            end else if (idx == SCTL_IDX) begin
                s_nxt.sysctl = PWDATA[7:0];
            end else if (idx == MCTL_IDX) begin
                // Force-latch is a strobe and never stored
                s_nxt.modctl = PWDATA[7:0] & ~(8'h01 << FORCE_BIT);
            end else if (idx == TEST_IDX) begin
                if (SPECIAL_MODE) begin
                    s_nxt.test = PWDATA[7:0];
                end
            end else if (idx == MCNT_IDX) begin
                s_nxt.mod_cnt  = PWDATA[15:0];
                s_nxt.mod_load = PWDATA[15:0];
            end
        end

        // Edge detection and capture per channel
        for (int c = 0; c < NCH; c++) begin
            cap_ev[c] = (s_r.edge_sel[2*c]   && CAPTURE_PIN[c] &&
                         !s_r.pin_prev[c]) ||
                        (s_r.edge_sel[2*c+1] && !CAPTURE_PIN[c] &&
                         s_r.pin_prev[c]);
            if (cap_ev[c]) begin
                // Accumulators count in every mode, buffered or not
                if (s_r.pacc[c] != PACC_MAX) begin
                    s_nxt.pacc[c] = s_r.pacc[c] + 8'h01;
                end else if (!s_r.sysctl[SAT_BIT]) begin
                    s_nxt.pacc[c] = 8'h00;
                end
                if (queue) begin
                    // Both full with no-overwrite: the edge is dropped
                    // Limitation: the accumulator still counts that edge
                    if (!(s_r.sysctl[NO_OVERWRITE_BIT] && s_r.cap_full[c] &&
                          s_r.hold_full[c])) begin
                        hold_ld[c] = s_r.cap_full[c];
                        if (hold_ld[c]) begin
                            s_nxt.hold[c]      = s_r.cap[c];
                            s_nxt.hold_full[c] = 1'b1;
                        end
                        s_nxt.cap[c]      = s_r.timer;
                        s_nxt.cap_full[c] = 1'b1;
                        if (!s_r.sysctl[FLAG_TIMING_SELECT_BIT] || hold_ld[c]) begin
                            s_nxt.flags[c] = 1'b1;
                        end
                    end
                end else begin
                    s_nxt.cap[c]      = s_r.timer;
                    s_nxt.cap_full[c] = 1'b1;
                    s_nxt.flags[c]    = 1'b1;
                end
            end
        end

        // Latch event takes the pre-edge values and restarts accumulation
        if (latch_ev) begin
            for (int c = 0; c < NCH; c++) begin
                s_nxt.hold[c]      = s_r.cap[c];
                s_nxt.pacc_hold[c] = s_r.pacc[c];
                s_nxt.pacc[c]      = 8'h00;
                s_nxt.hold_full[c] = 1'b1;
            end
        end

        // Read data is fetched in the setup phase for the access phase
        // Writes, idle cycles and unmapped words read back as zero
        s_nxt.rdata = 32'h0000_0000;
        if (PSEL && !PENABLE && !PWRITE) begin
            if (idx == TIMER_IDX) begin
                s_nxt.rdata[15:0] = s_r.timer;
            end else if (idx == EDGE_IDX) begin
                s_nxt.rdata[15:0] = s_r.edge_sel;
            end else if (idx == MASK_IDX) begin
                s_nxt.rdata[7:0] = s_r.mask;
            end else if (idx == FLAG_IDX) begin
                s_nxt.rdata[7:0] = s_r.flags;
            end else if (idx == SCTL_IDX) begin
                s_nxt.rdata[7:0] = s_r.sysctl;
            end else if (idx == MCTL_IDX) begin
                s_nxt.rdata[7:0] = s_r.modctl;
            end else if (idx == TEST_IDX) begin
                s_nxt.rdata[7:0] = s_r.test;
            end else if (idx == MCNT_IDX) begin
                s_nxt.rdata[15:0] = s_r.mod_cnt;
            end else begin
                for (int c = 0; c < NCH; c++) begin
                    if (idx == CAP_IDX + 10'(c)) begin
                        s_nxt.rdata[15:0] = s_r.cap[c];
                    end
                    if (idx == HOLD_IDX + 10'(c)) begin
                        s_nxt.rdata[15:0] = s_r.hold[c];
                    end
                    if (idx == PACC_IDX + 10'(c)) begin
                        s_nxt.rdata[7:0] = s_r.pacc[c];
                    end
                    if (idx == PHLD_IDX + 10'(c)) begin
                        s_nxt.rdata[7:0] = s_r.pacc_hold[c];
                    end
                end
            end
        end
    end

    // Synchronous reset clears every register, holding words included
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    a_rise_sets_flag: assert property (
        s_r.edge_sel[1:0] == 2'b01 && CAPTURE_PIN[0] && !s_r.pin_prev[0]
        && !s_r.sysctl[FLAG_TIMING_SELECT_BIT] && !queue |=> s_r.flags[0])
        else $error("rising edge did not set flag 0");
    a_mask_gates_irq: assert property (
        $rose(s_r.flags[0]) && s_r.mask[0] |-> IRQ)
        else $error("unmasked flag did not raise interrupt");
    a_flag_on_load: assert property (
        $rose(s_r.flags[0]) && $past(queue) &&
        $past(s_r.sysctl[FLAG_TIMING_SELECT_BIT]) |-> $past(hold_ld[0]))
        else $error("queue flag set without holding load");
    a_first_no_flag: assert property (
        queue && s_r.sysctl[FLAG_TIMING_SELECT_BIT] && s_r.sysctl[NO_OVERWRITE_BIT] &&
        !s_r.cap_full[0] && !s_r.hold_full[0] && cap_ev[0] &&
        !s_r.flags[0] && !latch_ev |=> !s_r.flags[0] && s_r.cap_full[0])
        else $error("first queued capture set the flag");
    a_pacc_sat: assert property (
        s_r.sysctl[SAT_BIT] && s_r.pacc[0] == PACC_MAX && cap_ev[0] &&
        !latch_ev |=> s_r.pacc[0] == PACC_MAX)
        else $error("saturated accumulator moved");
    a_pacc_wrap: assert property (
        !s_r.sysctl[SAT_BIT] && s_r.pacc[0] == PACC_MAX && cap_ev[0] &&
        !latch_ev |=> s_r.pacc[0] == 8'h00)
        else $error("accumulator did not wrap");
    a_nobuf_hold: assert property (
        !holding_buffer_enable |=> $stable(s_r.hold) && $stable(s_r.pacc_hold))
        else $error("holding changed with buffers off");
    a_latch_copy: assert property (
        latch_ev |=> s_r.hold[0] == $past(s_r.cap[0]) &&
        s_r.pacc[0] == 8'h00 && s_r.pacc_hold[0] == $past(s_r.pacc[0]))
        else $error("latch event did not copy and clear");
    a_queue_shift: assert property (
        queue && cap_ev[0] && s_r.cap_full[0] && !s_r.hold_full[0]
        && !latch_ev |=> s_r.hold[0] == $past(s_r.cap[0]) &&
        s_r.cap[0] == $past(s_r.timer))
        else $error("queue did not shift capture to holding");
    a_test_locked: assert property (
        wr_acc && idx == TEST_IDX && !SPECIAL_MODE |=> $stable(s_r.test))
        else $error("test register written outside special mode");

    // Further rule checks on channel 0, the interrupt mask, the shared latch path and the test register
    a_fall_sets_flag: assert property (
        s_r.edge_sel[1:0] == 2'b10 && !CAPTURE_PIN[0] && s_r.pin_prev[0]
        && !queue |=> s_r.flags[0])
        else $error("falling edge did not set flag 0");
    a_sel_off_quiet: assert property (
        s_r.edge_sel[1:0] == 2'b00 |-> !cap_ev[0])
        else $error("disabled channel detected an edge");
    a_flag_sticky: assert property (
        s_r.flags[0] && !(wr_acc && idx == FLAG_IDX && PWDATA[0])
        |=> s_r.flags[0])
        else $error("flag 0 cleared without a write of one");
    a_irq_masked: assert property (
        s_r.mask == 8'h00 |-> !IRQ)
        else $error("interrupt raised with every flag masked");
    a_no_overwrite_drop: assert property (
        queue && s_r.sysctl[NO_OVERWRITE_BIT] && s_r.cap_full[0] &&
        s_r.hold_full[0] && cap_ev[0] |=> $stable(s_r.cap[0]) &&
        $stable(s_r.hold[0]) && !$rose(s_r.flags[0]))
        else $error("no-overwrite let a capture through");
    a_pacc_inc: assert property (
        cap_ev[0] && s_r.pacc[0] != PACC_MAX && !latch_ev
        |=> s_r.pacc[0] == $past(s_r.pacc[0]) + 8'h01)
        else $error("accumulator did not count the edge");
    a_force_copy: assert property (
        wr_acc && idx == MCTL_IDX && PWDATA[FORCE_BIT] && holding_buffer_enable &&
        s_r.sysctl[LATCH_QUEUE_SELECT_BIT] |=> s_r.pacc_hold[0] == $past(s_r.pacc[0]))
        else $error("force-latch write did not copy the accumulator");
    a_zero_latch: assert property (
        wr_acc && idx == MCNT_IDX && PWDATA[15:0] == WORD_RST && holding_buffer_enable &&
        s_r.sysctl[LATCH_QUEUE_SELECT_BIT] |=> s_r.pacc == '0 && &s_r.hold_full)
        else $error("zero count write did not latch");
    a_mod_latch: assert property (
        s_r.modctl[MCEN_BIT] && s_r.mod_cnt == 16'h0001 && holding_buffer_enable &&
        s_r.sysctl[LATCH_QUEUE_SELECT_BIT] |=> s_r.pacc == '0 && &s_r.hold_full)
        else $error("modulus count reaching zero did not latch");
    a_test_special: assert property (
        wr_acc && idx == TEST_IDX && SPECIAL_MODE
        |=> s_r.test == $past(PWDATA[7:0]))
        else $error("test register ignored a special-mode write");
    a_cap_timer: assert property (
        cap_ev[0] && !queue |=> s_r.cap[0] == $past(s_r.timer))
        else $error("capture did not take the timer");

    c_queue_load: cover property (queue ##1 hold_ld[0]);
    c_mod_latch: cover property (mod_hit && latch_ev);
    c_irq: cover property ($rose(IRQ));
    c_no_overwrite_drop: cover property (queue && s_r.sysctl[NO_OVERWRITE_BIT] &&
        s_r.cap_full[0] && s_r.hold_full[0] && cap_ev[0]);
    c_sat_stop: cover property (s_r.sysctl[SAT_BIT] &&
        s_r.pacc[0] == PACC_MAX && cap_ev[0]);
endmodule : icbq_capture

// file: test/icbq_pin_src.sv
// Signal source model driving the capture pins
`timescale 1ns/1ps
module icbq_pin_src (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       SYS_RST,
    // Toggle request and pin levels
    input  wire logic [3:0] TOGGLE,
    output logic      [3:0] PINS
);
    // Levels move just after an edge, as a synchronous source would
    always_ff @(posedge CLK) begin
        if (SYS_RST) PINS <= 4'h0;
        else PINS <= PINS ^ TOGGLE;
    end
endmodule : icbq_pin_src

// file: test/input_capture_buffer_queue_tb.sv
// Self-checking bench for the input capture block
`timescale 1ns/1ps
module input_capture_buffer_queue_tb;
    import icbq_pkg::*;
    localparam logic [31:0] nv_m  = 32'h1 << NO_OVERWRITE_BIT;
    localparam logic [31:0] lq_m  = 32'h1 << LATCH_QUEUE_SELECT_BIT;
    localparam logic [31:0] bf_m  = 32'h1 << HOLDING_BUFFER_ENABLE_BIT;
    localparam logic [31:0] st_m  = 32'h1 << SAT_BIT;
    localparam logic [31:0] tf_m  = 32'h1 << FLAG_TIMING_SELECT_BIT;
    localparam logic [31:0] fl_m  = 32'h1 << FORCE_BIT;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rd, prdata, c;
    logic        pready, pslverr, irq, err;
    logic        smode = 1'b0;
    logic [3:0]  tog = 4'h0;
    logic [3:0]  pins;
    int          n_mismatch = 0;
    int          checks = 0;
    always #10 clk = ~clk;
    icbq_capture dut_u (.CLK(clk), .SYS_RST(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PREADY(pready), .PSLVERR(pslverr),
        .PRDATA(prdata), .CAPTURE_PIN(pins), .SPECIAL_MODE(smode),
        .IRQ(irq));
    icbq_pin_src src_u (.CLK(clk), .SYS_RST(rst), .TOGGLE(tog),
        .PINS(pins));
    task automatic apb(input logic w, input logic [9:0] i,
                       input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // Answer and read data are taken at the edge that sees pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rdchk(input logic [9:0] i, input logic [31:0] exp);
        apb(1'b0, i, 32'h0);
        chk(rd, exp);
    endtask : rdchk
    task automatic pulse(input int n);
        tog <= 4'h1;
        repeat (n) @(posedge clk);
        tog <= 4'h0;
        repeat (3) @(posedge clk);
    endtask : pulse
    task automatic t_reset();
        rdchk(FLAG_IDX, 32'h0);
        rdchk(SCTL_IDX, 32'h0);
        apb(1'b0, 10'h3ff, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
    endtask : t_reset
    task automatic t_edges();
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, EDGE_IDX, 32'(m));
            apb(1'b1, FLAG_IDX, 32'hff);
            pulse(1);
            rdchk(FLAG_IDX, 32'(m & 1));
            apb(1'b1, FLAG_IDX, 32'hff);
            pulse(1);
            rdchk(FLAG_IDX, 32'(m >> 1));
        end
        $display("test edges done");
    endtask : t_edges
    task automatic t_irq();
        apb(1'b1, MASK_IDX, 32'h0);
        pulse(2);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, MASK_IDX, 32'h1);
        @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, FLAG_IDX, 32'hff);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        $display("test irq done");
    endtask : t_irq
    task automatic t_queue();
        apb(1'b1, EDGE_IDX, 32'h1);
        apb(1'b1, SCTL_IDX, bf_m | tf_m | nv_m);
        apb(1'b0, CAP_IDX, 32'h0);
        apb(1'b1, FLAG_IDX, 32'hff);
        pulse(1);
        rdchk(FLAG_IDX, 32'h0);
        pulse(2);
        rdchk(FLAG_IDX, 32'h1);
        // Both registers full with no-overwrite: the next rise is dropped
        apb(1'b1, FLAG_IDX, 32'hff);
        pulse(3);
        rdchk(FLAG_IDX, 32'h0);
        // Without no-overwrite so the full holding reg cannot block
        apb(1'b1, SCTL_IDX, bf_m);
        apb(1'b0, CAP_IDX, 32'h0);
        pulse(3);
        apb(1'b0, CAP_IDX, 32'h0);
        c = rd;
        rdchk(HOLD_IDX, {16'h0, c[15:0] - 16'h2});
        pulse(1);
        $display("test queue done");
    endtask : t_queue
    task automatic t_latch();
        apb(1'b1, SCTL_IDX, bf_m | lq_m);
        apb(1'b1, MCNT_IDX, 32'h0);
        pulse(6);
        apb(1'b0, CAP_IDX, 32'h0);
        c = rd;
        apb(1'b1, MCTL_IDX, fl_m);
        rdchk(PHLD_IDX, 32'h3);
        rdchk(PACC_IDX, 32'h0);
        rdchk(HOLD_IDX, c);
        pulse(4);
        apb(1'b1, MCNT_IDX, 32'h0);
        rdchk(PHLD_IDX, 32'h2);
        pulse(2);
        apb(1'b1, SCTL_IDX, lq_m);
        apb(1'b1, MCTL_IDX, fl_m);
        rdchk(PHLD_IDX, 32'h2);
        for (int s = 1; s >= 0; s--) begin
            apb(1'b1, SCTL_IDX, bf_m | lq_m | (s != 0 ? st_m : 32'h0));
            apb(1'b1, MCNT_IDX, 32'h0);
            pulse(512);
            rdchk(PACC_IDX, s != 0 ? 32'hff : 32'h0);
        end
        // Periodic latch from the running modulus counter
        apb(1'b1, SCTL_IDX, bf_m | lq_m);
        apb(1'b1, MCNT_IDX, 32'h0);
        pulse(6);
        apb(1'b1, MCNT_IDX, 32'h40);
        apb(1'b1, MCTL_IDX, 32'h1 << MCEN_BIT);
        repeat (64) @(posedge clk);
        rdchk(PHLD_IDX, 32'h3);
        rdchk(PACC_IDX, 32'h0);
        apb(1'b1, MCTL_IDX, 32'h0);
        $display("test latch done");
    endtask : t_latch
    task automatic t_test();
        apb(1'b1, TEST_IDX, 32'h5a);
        rdchk(TEST_IDX, 32'h0);
        smode <= 1'b1;
        apb(1'b1, TEST_IDX, 32'h5a);
        rdchk(TEST_IDX, 32'h5a);
        $display("test testreg done");
    endtask : t_test
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_edges();
        t_irq();
        t_queue();
        t_latch();
        t_test();
        stop_test();
    end
    // Tests need some 1400 cycles; allow 20000
    initial begin
        #400000;
        n_mismatch++;
        stop_test();
    end
endmodule : input_capture_buffer_queue_tb
